// ---- bench/vfd_command_decoder_tb.sv ----
`timescale 1ns/1ps
module vfd_command_decoder_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] char_code = 8'h00;
    logic sclk;
    logic si;
    logic cs_n;
    logic [15:0] grid_out;
    logic dot_outputs;
    logic aux_segment_output;
    logic glyph_from_ram;
    logic standby_out;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'd90256;
    logic [15:0] exp_q [$];
    logic [15:0] res_val;
    string res_name;
    event res_ev;
    logic [15:0] lc [16];
    logic [15:0] dc [16];
    logic [15:0] ac [16];
    logic [15:0] ed [16];
    logic [15:0] ea [16];
    logic [7:0] q [$];
    logic [7:0] v;
    logic [15:0] dark;
    logic [7:0] bnd [4] = '{8'h07, 8'h08, 8'h00, 8'hff};
    logic [7:0] sbc [3] = '{8'hed, 8'hef, 8'hec};

    always #25 clk = ~clk;

    vfd_command_decoder vfd_command_decoder_i (
        .clk(clk),
        .srst(srst),
        .sclk(sclk),
        .si(si),
        .cs_n(cs_n),
        .char_code(char_code),
        .grid_out(grid_out),
        .dot_outputs(dot_outputs),
        .aux_segment_output(aux_segment_output),
        .glyph_from_ram(glyph_from_ram),
        .standby_out(standby_out)
    );

    vfd_host_model vfd_host_model_i (.sclk(sclk), .si(si), .cs_n(cs_n));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic note(input logic [15:0] x);
        exp_q.push_back(x);
    endtask : note

    task automatic show(input string nm, input logic [15:0] x);
        res_name = nm;
        res_val = x;
        -> res_ev;
        #1;
    endtask : show

    always @(res_ev) begin
        check(res_name, res_val, exp_q.pop_front());
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic cmd(input logic [7:0] b [$]);
        // Start off the rising edge so pins never race the sync flops
        @(negedge clk);
        vfd_host_model_i.frame_start();
        foreach (b[i]) vfd_host_model_i.put_byte(b[i]);
        vfd_host_model_i.frame_end();
        repeat (4) @(posedge clk);
    endtask : cmd

    // Aligns to a frame start so every slot is counted whole
    task automatic measure();
        for (int g = 0; g < 16; g++) begin
            lc[g] = 16'h0;
            dc[g] = 16'h0;
            ac[g] = 16'h0;
        end
        for (int k = 0; k < 9000 && grid_out !== 16'h8000; k++)
            @(negedge clk);
        for (int k = 0; k < 300 && grid_out !== 16'h0001; k++)
            @(negedge clk);
        for (int c = 0; c < 4080; c++) begin
            for (int j = 0; j < 16; j++) begin
                if (grid_out[j] === 1'b1) begin
                    lc[j] = lc[j] + 16'h1;
                    dc[j] = dc[j] + {15'h0, dot_outputs};
                    ac[j] = ac[j] + {15'h0, aux_segment_output};
                end
            end
            @(negedge clk);
        end
    endtask : measure

    task automatic frame_check(input string tname);
        for (int g = 0; g < 16; g++) begin
            note(16'd255);
            note(ed[g]);
            note(ea[g]);
        end
        measure();
        for (int g = 0; g < 16; g++) begin
            show("slot", lc[g]);
            show("dots", dc[g]);
            show("aux", ac[g]);
        end
        $display("test %s done", tname);
    endtask : frame_check

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        note(16'h0000);
        show("grid", grid_out);
        note(16'h0000);
        show("outs", {13'h0, dot_outputs, aux_segment_output, standby_out});
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            v = (i < 4) ? bnd[i] : rnd[7:0];
            @(posedge clk);
            char_code <= v;
            note({15'h0, v <= 8'h07});
            @(posedge clk);
            @(negedge clk);
            show("glyph", {15'h0, glyph_from_ram});
        end
        $display("test glyph done");
        foreach (sbc[i]) begin
            q = {sbc[i]};
            cmd(q);
            note({15'h0, sbc[i][0]});
            show("standby", {15'h0, standby_out});
        end
        $display("test standby done");
        // Levels go in before the lamp is lit
        q = {8'he0, 8'h0f};
        cmd(q);
        // Bit seven set: the eight-grid nibble must not be taken
        q = {8'he0, 8'h87};
        cmd(q);
        q = {8'he4, 8'h80};
        cmd(q);
        q = {8'he8};
        cmd(q);
        for (int g = 0; g < 16; g++) begin
            ed[g] = 16'd128;
            ea[g] = 16'd0;
        end
        frame_check("dimming");
        q = {8'h60};
        for (int i = 0; i < 25; i++) begin
            rnd = lfsr(rnd);
            q.push_back(rnd[7:0]);
        end
        cmd(q);
        for (int g = 0; g < 16; g++) begin
            ed[g] = (g < 2) ? 16'd64 : 16'd240;
            ea[g] = q[g + 1][0] ? ((g == 0 || g == 2) ? 16'd32 : 16'd240)
                : 16'd0;
        end
        q = {8'he4, 8'hff};
        cmd(q);
        q = {8'ha0, 8'h40, 8'h20, 8'h99};
        cmd(q);
        q = {8'hc0, 8'h05, 8'h01, 8'h04, 8'hfa};
        cmd(q);
        frame_check("segments");
        q = {8'he9};
        cmd(q);
        note(16'd255);
        measure();
        show("full", dc[5]);
        q = {8'hea};
        cmd(q);
        dark = 16'h0;
        for (int c = 0; c < 4100; c++) begin
            @(negedge clk);
            dark = dark + {15'h0, grid_out !== 16'h0};
        end
        note(16'h0000);
        show("dark", dark);
        $display("test lamp done");
        q = {8'hed};
        cmd(q);
        @(posedge clk);
        srst <= 1'b1;
        repeat (vfd_cmd_pkg::RST_MIN_CYC) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        note(16'h0000);
        show("rerun", grid_out);
        note(16'h0000);
        show("rerun_standby", {15'h0, standby_out});
        $display("test rerun done");
        finish_test();
    end
endmodule : vfd_command_decoder_tb

// ---- bench/vfd_host_model.sv ----
`timescale 1ns/1ps
module vfd_host_model (
    output logic sclk,
    output logic si,
    output logic cs_n
);
    initial begin
        sclk = 1'b0;
        si = 1'b0;
        cs_n = 1'b1;
    end

    // Link clock stands low between frames; data shows the inverted last bit
    task automatic frame_start();
        si = ~si;
        #300 cs_n = 1'b0;
        #300;
    endtask : frame_start

    task automatic put_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            si = b[i];
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        #2000;
    endtask : put_byte

    task automatic frame_end();
        cs_n = 1'b1;
        si = ~si;
        #600;
    endtask : frame_end
endmodule : vfd_host_model

// ---- design/vfd_cmd_pkg.sv ----
package vfd_cmd_pkg;

    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int GAP_MIN_NS = 2000;
    localparam int GAP_MIN_CYC =
        (GAP_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_MIN_NS = 15000;
    localparam int RST_MIN_CYC =
        (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Scan geometry
    localparam int SCAN_DEPTH = 24;
    localparam int GRIDS = 16;
    localparam int DUTY_STEPS = 255;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [3:0] GRAY_ADDR_END = 4'h8;

    // Reset values and limits
    localparam logic [3:0] TIMING_RST = 4'hf;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [7:0] LEVEL_MAX = 8'hf0;
    localparam logic [7:0] GLYPH_RAM_LAST = 8'h07;

    // Command opcodes
    localparam logic [2:0] OP_EXT_SEG = 3'h3;
    localparam logic [2:0] OP_GRAY = 3'h5;
    localparam logic [2:0] OP_GRAY_EN = 3'h6;
    localparam logic [5:0] OP_TIMING = 6'h38;
    localparam logic [5:0] OP_DIM = 6'h39;
    localparam logic [5:0] OP_LAMP = 6'h3a;
    localparam logic [5:0] OP_STANDBY = 6'h3b;

    // Field positions
    localparam int GEN_DOTS_BIT = 0;
    localparam int GEN_AUX_BIT = 2;
    localparam int LAMP_OFF_POS = 1;
    localparam int LAMP_HIGH_POS = 0;
    localparam logic [3:0] TIMING_16G = 4'hf;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_EXT = 6'h02,
        ST_TIM = 6'h04,
        ST_DIM = 6'h08,
        ST_GRAY = 6'h10,
        ST_GEN = 6'h20
    } dec_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic first;
    } rx_byte_t;

    typedef struct packed {
        logic dots;
        logic aux;
    } gray_en_t;

endpackage : vfd_cmd_pkg

// ---- design/vfd_command_decoder.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Opcode 011 with address starts extra-segment writes
// - Extra-segment data auto-increments 00H to 17H
// - Data bit zero sets the auxiliary segment
// - Stored bit drives aux output per timing
// - Opcode 111000 then one display-timing byte
// - Timing byte: bit7 zero, nibble 1111 is 16 grids
// - Reset sets timing to grids 1 to 16
// - Opcode 111001 then one dimming byte
// - Dimming n gives min(n, 240)/255 on-duty
// - Reset clears dimming, gray levels, gray enables
// - Opcode 101 with address then gray bytes
// - Gray address auto-increments 0H to 7H
// - Address 0 dots, 1 aux, rest ignored
// - Opcode 110 with address then enable bytes
// - Enable bit0 dots, bit2 aux
// - Enabled outputs use gray pulse width
// - Opcode 111010 sets lamp off and high bits
// - Opcode 111011 bit zero enters stand-by
// - Codes 00H-07H select the user glyph RAM
// - Reset clears extra-segment RAM to 00H
module vfd_command_decoder (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic si,
    input wire logic cs_n,
    input wire logic [7:0] char_code,
    output logic [15:0] grid_out,
    output logic dot_outputs,
    output logic aux_segment_output,
    output logic glyph_from_ram,
    output logic standby_out
);

    typedef struct packed {
        vfd_cmd_pkg::dec_state_t state;
        logic [4:0] wptr;
        logic [3:0] gaddr;
        logic [3:0] timing;
        logic [7:0] dimming_value;
        logic [7:0] gray_dots;
        logic [7:0] gray_aux;
        logic lamp_off_bit;
        logic lamp_high_bit;
        logic standby_bit;
        logic [3:0] grid_idx;
        logic [7:0] duty;
        logic [15:0] grid;
        logic dots;
        logic aux;
        logic glyph_sel;
    } dec_st_t;

    dec_st_t s_r;
    dec_st_t s_nxt;

    vfd_cmd_pkg::rx_byte_t rx_byte;
    logic rx_valid;
    logic [7:0] rx_data;
    logic data_byte;
    logic ext_we;
    logic gen_we;
    logic [1:0] gen_wdata;
    logic [4:0] raddr;
    logic extra_segment_ram_q;
    vfd_cmd_pkg::gray_en_t gen_q;
    logic blank;
    logic [7:0] width_dots;
    logic [7:0] width_aux;
    logic slot_end;

    function automatic logic [7:0] clamp_level(input logic [7:0] v);
        clamp_level = (v > vfd_cmd_pkg::LEVEL_MAX) ?
            vfd_cmd_pkg::LEVEL_MAX : v;
    endfunction : clamp_level

    function automatic logic [3:0] next_grid(input logic [3:0] idx,
                                             input logic [3:0] last);
        next_grid = (idx >= last) ? 4'h0 : idx + 4'h1;
    endfunction : next_grid

    vfd_serial_rx u_rx (
        .clk(clk),
        .srst(srst),
        .sclk(sclk),
        .si(si),
        .cs_n(cs_n),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid)
    );

    vfd_scan_ram #(.WIDTH(1), .DEPTH(vfd_cmd_pkg::SCAN_DEPTH)) u_ext_ram (
        .clk(clk),
        .srst(srst),
        .we(ext_we),
        .waddr(s_r.wptr),
        .wdata(rx_data[0]),
        .raddr(raddr),
        .rdata(extra_segment_ram_q)
    );

    vfd_scan_ram #(.WIDTH(2), .DEPTH(vfd_cmd_pkg::SCAN_DEPTH)) u_gen_ram (
        .clk(clk),
        .srst(srst),
        .we(gen_we),
        .waddr(s_r.wptr),
        .wdata(gen_wdata),
        .raddr(raddr),
        .rdata(gen_q)
    );

    assign rx_data = rx_byte.data;
    assign data_byte = rx_valid && !rx_byte.first;
    assign slot_end = (s_r.duty == 8'(vfd_cmd_pkg::DUTY_STEPS - 1));
    // Fetch one cycle early so the registered read is ready at slot start
    assign raddr = {1'b0, slot_end ?
        next_grid(s_r.grid_idx, s_r.timing) : s_r.grid_idx};
    assign blank = s_r.standby_bit || s_r.lamp_off_bit;
    assign width_dots = gen_q.dots ? clamp_level(s_r.gray_dots) :
        clamp_level(s_r.dimming_value);
    assign width_aux = gen_q.aux ? clamp_level(s_r.gray_aux) :
        clamp_level(s_r.dimming_value);
    assign gen_wdata = {rx_data[vfd_cmd_pkg::GEN_DOTS_BIT],
                        rx_data[vfd_cmd_pkg::GEN_AUX_BIT]};

    always_comb begin
        s_nxt = s_r;
        ext_we = 1'b0;
        gen_we = 1'b0;
        if (rx_valid && rx_byte.first) begin
            // A command byte always wins over a running sequence
            s_nxt.state = vfd_cmd_pkg::ST_IDLE;
            case (rx_data[7:5])
                vfd_cmd_pkg::OP_EXT_SEG: begin
                    s_nxt.state = vfd_cmd_pkg::ST_EXT;
                    s_nxt.wptr = rx_data[4:0];
                end
                vfd_cmd_pkg::OP_GRAY: begin
                    s_nxt.state = vfd_cmd_pkg::ST_GRAY;
                    s_nxt.gaddr = {1'b0, rx_data[2:0]};
                end
                vfd_cmd_pkg::OP_GRAY_EN: begin
                    s_nxt.state = vfd_cmd_pkg::ST_GEN;
                    s_nxt.wptr = rx_data[4:0];
                end
                default: begin
                    case (rx_data[7:2])
                        vfd_cmd_pkg::OP_TIMING: begin
                            s_nxt.state = vfd_cmd_pkg::ST_TIM;
                        end
                        vfd_cmd_pkg::OP_DIM: begin
                            s_nxt.state = vfd_cmd_pkg::ST_DIM;
                        end
                        vfd_cmd_pkg::OP_LAMP: begin
                            s_nxt.lamp_off_bit =
                                rx_data[vfd_cmd_pkg::LAMP_OFF_POS];
                            s_nxt.lamp_high_bit =
                                rx_data[vfd_cmd_pkg::LAMP_HIGH_POS];
                        end
                        vfd_cmd_pkg::OP_STANDBY: begin
                            s_nxt.standby_bit = rx_data[0];
                        end
                        default: begin
                            s_nxt.state = vfd_cmd_pkg::ST_IDLE;
                        end
                    endcase
                end
            endcase
        end else if (data_byte) begin
            case (s_r.state)
                vfd_cmd_pkg::ST_EXT: begin
                    // Writes past 17H are dropped rather than wrapped
                    if (s_r.wptr <= vfd_cmd_pkg::ADDR_LAST) begin
                        ext_we = 1'b1;
                        s_nxt.wptr = s_r.wptr + 5'h1;
                    end
                end
                vfd_cmd_pkg::ST_GEN: begin
                    if (s_r.wptr <= vfd_cmd_pkg::ADDR_LAST) begin
                        gen_we = 1'b1;
                        s_nxt.wptr = s_r.wptr + 5'h1;
                    end
                end
                vfd_cmd_pkg::ST_GRAY: begin
                    if (s_r.gaddr == 4'h0) begin
                        s_nxt.gray_dots = rx_data;
                    end
                    if (s_r.gaddr == 4'h1) begin
                        s_nxt.gray_aux = rx_data;
                    end
                    if (s_r.gaddr != vfd_cmd_pkg::GRAY_ADDR_END) begin
                        s_nxt.gaddr = s_r.gaddr + 4'h1;
                    end
                end
                vfd_cmd_pkg::ST_TIM: begin
                    if (!rx_data[7]) begin
                        s_nxt.timing = rx_data[3:0];
                    end
                    s_nxt.state = vfd_cmd_pkg::ST_IDLE;
                end
                vfd_cmd_pkg::ST_DIM: begin
                    s_nxt.dimming_value = rx_data;
                    s_nxt.state = vfd_cmd_pkg::ST_IDLE;
                end
                default: begin
                    s_nxt.state = vfd_cmd_pkg::ST_IDLE;
                end
            endcase
        end

        // Grid scan: each slot is split into 255 duty steps
        if (slot_end) begin
            s_nxt.duty = 8'h00;
            s_nxt.grid_idx = next_grid(s_r.grid_idx, s_r.timing);
        end else begin
            s_nxt.duty = s_r.duty + 8'h01;
        end
        s_nxt.grid = blank ? 16'h0000 : (16'h0001 << s_r.grid_idx);
        s_nxt.dots = !blank &&
            (s_r.lamp_high_bit || s_r.duty < width_dots);
        s_nxt.aux = !blank && extra_segment_ram_q &&
            (s_r.lamp_high_bit || s_r.duty < width_aux);
        s_nxt.glyph_sel =
            (char_code <= vfd_cmd_pkg::GLYPH_RAM_LAST);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
            s_r.state <= vfd_cmd_pkg::ST_IDLE;
            s_r.timing <= vfd_cmd_pkg::TIMING_RST;
            s_r.dimming_value <= vfd_cmd_pkg::LEVEL_RST;
            s_r.gray_dots <= vfd_cmd_pkg::LEVEL_RST;
            s_r.gray_aux <= vfd_cmd_pkg::LEVEL_RST;
            s_r.lamp_off_bit <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign grid_out = s_r.grid;
    assign dot_outputs = s_r.dots;
    assign aux_segment_output = s_r.aux;
    assign glyph_from_ram = s_r.glyph_sel;
    assign standby_out = s_r.standby_bit;

    property p_reset_dark;
        @(posedge clk) disable iff (1'b0)
        srst |=> grid_out == 16'h0000 && !dot_outputs && !aux_segment_output
            && s_r.timing == vfd_cmd_pkg::TIMING_16G;
    endproperty
    a_reset_dark: assert property (p_reset_dark)
        else $error("outputs not dark or timing wrong after reset");

    property p_dim_store;
        @(posedge clk) disable iff (srst)
        (data_byte && s_r.state == vfd_cmd_pkg::ST_DIM)
            |=> s_r.dimming_value == $past(rx_data)
                && s_r.state == vfd_cmd_pkg::ST_IDLE;
    endproperty
    a_dim_store: assert property (p_dim_store)
        else $error("dimming byte not stored");

    property p_ext_inc;
        @(posedge clk) disable iff (srst)
        (data_byte && s_r.state == vfd_cmd_pkg::ST_EXT
            && s_r.wptr <= vfd_cmd_pkg::ADDR_LAST)
            |-> ext_we ##1 s_r.wptr == $past(s_r.wptr) + 5'h1;
    endproperty
    a_ext_inc: assert property (p_ext_inc)
        else $error("extra-segment address did not advance");

    property p_ext_stop;
        @(posedge clk) disable iff (srst)
        (s_r.wptr > vfd_cmd_pkg::ADDR_LAST && !(rx_valid && rx_byte.first))
            |-> !ext_we && !gen_we;
    endproperty
    a_ext_stop: assert property (p_ext_stop)
        else $error("write beyond last scan address");

    property p_gray_ignore;
        @(posedge clk) disable iff (srst)
        (data_byte && s_r.state == vfd_cmd_pkg::ST_GRAY && s_r.gaddr > 4'h1)
            |=> $stable(s_r.gray_dots) && $stable(s_r.gray_aux);
    endproperty
    a_gray_ignore: assert property (p_gray_ignore)
        else $error("gray write to unused address took effect");

    property p_standby_blank;
        @(posedge clk) disable iff (srst)
        (rx_valid && rx_byte.first && rx_data == 8'hed)
            |=> standby_out ##1 (grid_out == 16'h0000 && !dot_outputs);
    endproperty
    a_standby_blank: assert property (p_standby_blank)
        else $error("stand-by did not blank the display");

    property p_dim_duty;
        @(posedge clk) disable iff (srst)
        (!blank && !s_r.lamp_high_bit && !gen_q.dots
            && s_r.duty >= clamp_level(s_r.dimming_value))
            |=> !dot_outputs;
    endproperty
    a_dim_duty: assert property (p_dim_duty)
        else $error("dots lit past the dimming width");

    property p_restart;
        @(posedge clk) disable iff (srst)
        (rx_valid && rx_byte.first && rx_data[7:2] == vfd_cmd_pkg::OP_LAMP)
            |=> s_r.state == vfd_cmd_pkg::ST_IDLE
                && s_r.lamp_off_bit == $past(rx_data[1]);
    endproperty
    a_restart: assert property (p_restart)
        else $error("command byte did not restart decoding");

    property p_glyph;
        @(posedge clk) disable iff (srst)
        (char_code > vfd_cmd_pkg::GLYPH_RAM_LAST) |=> !glyph_from_ram;
    endproperty
    a_glyph: assert property (p_glyph)
        else $error("fixed glyph code routed to glyph RAM");

    property p_timing_keep;
        @(posedge clk) disable iff (srst)
        (data_byte && s_r.state == vfd_cmd_pkg::ST_TIM && rx_data[7])
            |=> $stable(s_r.timing) && s_r.state == vfd_cmd_pkg::ST_IDLE;
    endproperty
    a_timing_keep: assert property (p_timing_keep)
        else $error("timing byte with bit seven set was applied");

    property p_gray_inc;
        @(posedge clk) disable iff (srst)
        (data_byte && s_r.state == vfd_cmd_pkg::ST_GRAY
            && s_r.gaddr != vfd_cmd_pkg::GRAY_ADDR_END)
            |=> s_r.gaddr == $past(s_r.gaddr) + 4'h1;
    endproperty
    a_gray_inc: assert property (p_gray_inc)
        else $error("gray address did not advance");

    property p_gen_inc;
        @(posedge clk) disable iff (srst)
        (data_byte && s_r.state == vfd_cmd_pkg::ST_GEN
            && s_r.wptr <= vfd_cmd_pkg::ADDR_LAST)
            |-> gen_we ##1 s_r.wptr == $past(s_r.wptr) + 5'h1;
    endproperty
    a_gen_inc: assert property (p_gen_inc)
        else $error("gray enable address did not advance");

    property p_lamp_full;
        @(posedge clk) disable iff (srst)
        (!blank && s_r.lamp_high_bit) |=> dot_outputs;
    endproperty
    a_lamp_full: assert property (p_lamp_full)
        else $error("high lamp bit did not light the dots fully");

endmodule : vfd_command_decoder

// ---- design/vfd_scan_ram.sv ----
`timescale 1ns/1ps
module vfd_scan_ram #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 24
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [4:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    if (DEPTH < 1 || DEPTH > 32 || WIDTH < 1) begin : g_check
        $error("vfd_scan_ram: unsupported geometry");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } ram_state_t;

    ram_state_t s_r;
    ram_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (we && int'(waddr) < DEPTH) begin
            s_nxt.mem[waddr] = wdata;
        end
        s_nxt.rd = (int'(raddr) < DEPTH) ? s_r.mem[raddr] : '0;
    end

    // Whole array clears at reset so every entry starts at zero
    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rd;

endmodule : vfd_scan_ram

// ---- design/vfd_serial_rx.sv ----
`timescale 1ns/1ps
module vfd_serial_rx (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic si,
    input wire logic cs_n,
    output vfd_cmd_pkg::rx_byte_t rx_byte,
    output logic rx_valid
);

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic sclk_d;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic first;
        vfd_cmd_pkg::rx_byte_t out;
        logic valid;
    } rx_state_t;

    rx_state_t s_r;
    rx_state_t s_nxt;
    logic [7:0] shifted;

    // Pins sampled LSB first on the rising edge of the link clock
    always_comb begin
        s_nxt = s_r;
        shifted = {s_r.sync2[1], s_r.shift[7:1]};
        s_nxt.sync1 = {cs_n, si, sclk};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sclk_d = s_r.sync2[0];
        s_nxt.valid = 1'b0;
        if (s_r.sync2[2]) begin
            // Idle frame: next byte is a command byte
            s_nxt.cnt = 3'h0;
            s_nxt.first = 1'b1;
        end else if (s_r.sync2[0] && !s_r.sclk_d) begin
            s_nxt.shift = shifted;
            s_nxt.cnt = s_r.cnt + 3'h1;
            if (s_r.cnt == 3'h7) begin
                s_nxt.out = '{data: shifted, first: s_r.first};
                s_nxt.valid = 1'b1;
                s_nxt.first = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_r <= '0;
            s_r.sync1 <= 3'h7;
            s_r.sync2 <= 3'h7;
            s_r.first <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rx_byte = s_r.out;
    assign rx_valid = s_r.valid;

endmodule : vfd_serial_rx
